/* core/phm_pkg.sv */
`default_nettype none
package phm_pkg;
    // Port widths
    localparam int PHM_H_W = 7;
    localparam int PHM_J_W = 4;
    localparam int PHM_K_W = 7;
    localparam int PHM_M_W = 4;
    // Port J packed bit positions: pins 0,1,6,7
    localparam int PHM_J_P0 = 0;
    localparam int PHM_J_P1 = 1;
    localparam int PHM_J_P6 = 2;
    localparam int PHM_J_P7 = 3;
    // Port K packed positions: bits 5..0 address, bit 6 holds pin 7
    localparam int PHM_K_CS = 6;
    localparam int PHM_EXPANDED_BUS_UPPER_ADDRESS_W = 6;
    // Port M packed positions: pins 4..7 at 0..3
    localparam int PHM_M_P4 = 0;
    localparam int PHM_M_P5 = 1;
    // Reset values
    localparam logic PHM_FLASH_MAP_RST = 1'h0;
    localparam logic PHM_CS_IDLE_N = 1'h1;
    // Pin function selects for multi-role pins
    typedef enum logic [1:0] {
        PHM_FN_GPIO = 2'b00,
        PHM_FN_ALT_A = 2'b01,
        PHM_FN_ALT_B = 2'b10
    } phm_fn_e;
endpackage
`default_nettype wire

/* core/phm_pad_if.sv */
`default_nettype none
// One group of pads between the mux and its pad cells
interface phm_pad_if #(parameter int W = 4);
    logic [W-1:0] gp_out;
    logic [W-1:0] gp_dir;
    logic [W-1:0] alt_out;
    logic [W-1:0] alt_dir;
    logic [W-1:0] alt_en;
    logic [W-1:0] pin_out;
    logic [W-1:0] pin_oe_n;
    modport mux (input gp_out, gp_dir, alt_out, alt_dir, alt_en, output pin_out, pin_oe_n);
    modport ctl (output gp_out, gp_dir, alt_out, alt_dir, alt_en, input pin_out, pin_oe_n);
endinterface
`default_nettype wire

/* core/phm_pad_mux.sv */
`default_nettype none
module phm_pad_mux #(
    parameter int W = 4
) (
    input wire logic clk, // Bus clock
    input wire logic srst, // Sync reset
    phm_pad_if.mux pads // Pad group
);
    logic [W-1:0] out_next;
    logic [W-1:0] oe_n_next;
    logic [W-1:0] out_reg;
    logic [W-1:0] oe_n_reg;
    // Alternate function wins over general-purpose setting per pin
    assign out_next = (pads.alt_en & pads.alt_out) | (~pads.alt_en & pads.gp_out);
    assign oe_n_next = ~((pads.alt_en & pads.alt_dir) | (~pads.alt_en & pads.gp_dir));
    // Registered so every pad drive comes from a flop; all pads input at reset
    always_ff @(posedge clk) begin
        if (srst) begin
            out_reg <= '0;
            oe_n_reg <= '1;
        end else begin
            out_reg <= out_next;
            oe_n_reg <= oe_n_next;
        end
    end
    assign pads.pin_out = out_reg;
    assign pads.pin_oe_n = oe_n_reg;
endmodule // phm_pad_mux
`default_nettype wire

/* core/phm_wake_det.sv */
`default_nettype none
module phm_wake_det #(
    parameter int W = 7
) (
    input wire logic clk, // Bus clock
    input wire logic srst, // Sync reset
    input wire logic [W-1:0] pin_in, // Pin levels
    input wire logic [W-1:0] wake_en, // Per-pin enable
    input wire logic [W-1:0] wake_rise, // 1 = rising edge, 0 = falling
    input wire logic [W-1:0] flag_clr, // Write-one-to-clear
    output logic [W-1:0] flag // Sticky wake flags
);
    logic [W-1:0] last_reg;
    logic [W-1:0] flag_reg;
    logic [W-1:0] edge_hit;
    logic [W-1:0] flag_next;
    // Edge of selected polarity on an enabled pin
    assign edge_hit = wake_en & ((wake_rise & pin_in & ~last_reg)
        | (~wake_rise & ~pin_in & last_reg));
    // New edge beats a clear in the same cycle
    assign flag_next = (flag_reg & ~flag_clr) | edge_hit;
    // Edge memory follows the pad in reset, so a pin idling high gives no false edge
    always_ff @(posedge clk) begin
        if (srst) begin
            last_reg <= pin_in;
            flag_reg <= '0;
        end else begin
            last_reg <= pin_in;
            flag_reg <= flag_next;
        end
    end
    assign flag = flag_reg;
endmodule // phm_wake_det
`default_nettype wire

/* core/phm_port_mux.sv */
`default_nettype none
// What this block does
// - Port H pins 0 to 6 are general I/O and each may raise a wake-up from stop or wait.
// - Port J pins 1 and 0 are general I/O and each may raise a wake-up interrupt.
// - Port J pin 7 is general I/O with wake-up, or the I2C clock, or the CAN transmit.
// - Port J pin 6 is general I/O with wake-up, or the I2C data, or the CAN receive.
// - Port K pin 7 is general I/O alone, but in expanded modes drives the low-true chip select.
// - At reset release the level of port K pin 7 is captured into the flash map enable bit.
// - Port K pins 5 to 0 are general I/O, or in expanded modes address bits 19 to 14.
// - Port M pins 7 and 6 are general I/O only.
// - Port M pin 5 is general I/O, or the CAN transmit, or the SPI clock.
// - Port M pin 4 is general I/O, CAN receive, or SPI MOSI, output as master, input as slave.
module phm_port_mux
    import phm_pkg::*;
(
    input wire logic clk, // 25 MHz bus clock
    input wire logic srst, // Sync reset, high
    input wire logic expanded_mode, // Expanded bus modes active
    // General-purpose port data and direction (1 = output)
    input wire logic [PHM_H_W-1:0] port_h_out, // Port H data
    input wire logic [PHM_H_W-1:0] port_h_dir, // Port H direction
    input wire logic [PHM_J_W-1:0] port_j_out, // Port J data (7,6,1,0)
    input wire logic [PHM_J_W-1:0] port_j_dir, // Port J direction
    input wire logic [PHM_K_W-1:0] port_k_out, // Port K data (bit 6 is pin 7)
    input wire logic [PHM_K_W-1:0] port_k_dir, // Port K direction
    input wire logic [PHM_M_W-1:0] port_m_out, // Port M data (7..4)
    input wire logic [PHM_M_W-1:0] port_m_dir, // Port M direction
    // Wake-up controls
    input wire logic [PHM_H_W-1:0] port_h_wake_en, // Port H wake enable
    input wire logic [PHM_H_W-1:0] port_h_wake_rise, // Port H edge polarity
    input wire logic [PHM_H_W-1:0] port_h_wake_clr, // Port H flag clear
    input wire logic [PHM_J_W-1:0] port_j_wake_en, // Port J wake enable
    input wire logic [PHM_J_W-1:0] port_j_wake_rise, // Port J edge polarity
    input wire logic [PHM_J_W-1:0] port_j_wake_clr, // Port J flag clear
    // Function selects
    input wire logic [1:0] pj7_fn_sel, // Pin J7: gpio, I2C, CAN
    input wire logic [1:0] pj6_fn_sel, // Pin J6: gpio, I2C, CAN
    input wire logic [1:0] pm5_fn_sel, // Pin M5: gpio, CAN, SPI
    input wire logic [1:0] pm4_fn_sel, // Pin M4: gpio, CAN, SPI
    // Peripheral sides
    input wire logic i2c_scl_drive_low, // I2C clock pull-down
    input wire logic i2c_sda_drive_low, // I2C data pull-down
    input wire logic can_transmit_out, // CAN controller zero transmit
    input wire logic spi_sck_out, // SPI clock out
    input wire logic spi_sck_oe, // SPI drives clock (master)
    input wire logic spi_mosi_out, // SPI MOSI data out
    input wire logic spi_master, // SPI master mode
    input wire logic emulation_cs_active, // Emulation access in progress
    input wire logic [PHM_EXPANDED_BUS_UPPER_ADDRESS_W-1:0] expanded_bus_upper_address, // Address 19..14
    // Pad inputs
    input wire logic [PHM_H_W-1:0] port_h_pin_in, // Port H pad levels
    input wire logic [PHM_J_W-1:0] port_j_pin_in, // Port J pad levels
    input wire logic [PHM_K_W-1:0] port_k_pin_in, // Port K pad levels
    input wire logic [PHM_M_W-1:0] port_m_pin_in, // Port M pad levels
    // Pad outputs; enables low while driving
    output logic [PHM_H_W-1:0] port_h_pin_out, // Port H drive
    output logic [PHM_H_W-1:0] port_h_pin_oe_n, // Port H enable
    output logic [PHM_J_W-1:0] port_j_pin_out, // Port J drive
    output logic [PHM_J_W-1:0] port_j_pin_oe_n, // Port J enable
    output logic [PHM_K_W-1:0] port_k_pin_out, // Port K drive
    output logic [PHM_K_W-1:0] port_k_pin_oe_n, // Port K enable
    output logic [PHM_M_W-1:0] port_m_pin_out, // Port M drive
    output logic [PHM_M_W-1:0] port_m_pin_oe_n, // Port M enable
    // Peripheral and status outputs
    output logic i2c_scl_in, // I2C clock level
    output logic i2c_sda_in, // I2C data level
    output logic can_receive_in, // CAN controller zero receive
    output logic spi_sck_in, // SPI clock in (slave)
    output logic spi_mosi_in, // SPI MOSI in (slave)
    output logic [PHM_H_W-1:0] port_h_wake_input, // Port H wake flags
    output logic [PHM_J_W-1:0] port_j_wake_input, // Port J wake flags
    output logic wake_request, // Any wake flag set
    output logic flash_map_enable_bit // Strap latched at reset
);
    ////////////////////////////////////////////////////////////////////////////
    // Function decode
    phm_fn_e j7_fn, j6_fn, m5_fn, m4_fn;
    assign j7_fn = phm_fn_e'(pj7_fn_sel);
    assign j6_fn = phm_fn_e'(pj6_fn_sel);
    assign m5_fn = phm_fn_e'(pm5_fn_sel);
    assign m4_fn = phm_fn_e'(pm4_fn_sel);

    // One select code against one role; used for all four shared pins
    function automatic logic fn_is(input phm_fn_e f, input phm_fn_e want);
        fn_is = (f == want);
    endfunction

    wire j7_i2c = fn_is(j7_fn, PHM_FN_ALT_A);
    wire j7_can = fn_is(j7_fn, PHM_FN_ALT_B);
    wire j6_i2c = fn_is(j6_fn, PHM_FN_ALT_A);
    wire j6_can = fn_is(j6_fn, PHM_FN_ALT_B);
    wire m5_can = fn_is(m5_fn, PHM_FN_ALT_A);
    wire m5_spi = fn_is(m5_fn, PHM_FN_ALT_B);
    wire m4_can = fn_is(m4_fn, PHM_FN_ALT_A);
    wire m4_spi = fn_is(m4_fn, PHM_FN_ALT_B);

    ////////////////////////////////////////////////////////////////////////////
    // Port H: general I/O only, no alternate role
    phm_pad_if #(.W(PHM_H_W)) h_if ();
    assign h_if.gp_out = port_h_out;
    assign h_if.gp_dir = port_h_dir;
    assign h_if.alt_out = '0;
    assign h_if.alt_dir = '0;
    assign h_if.alt_en = '0;
    phm_pad_mux #(.W(PHM_H_W)) u_h_mux (.clk(clk), .srst(srst), .pads(h_if.mux));
    assign port_h_pin_out = h_if.pin_out;
    assign port_h_pin_oe_n = h_if.pin_oe_n;

    ////////////////////////////////////////////////////////////////////////////
    // Port J: I2C is open drain, so it only drives low and releases otherwise
    logic [PHM_J_W-1:0] j_alt_out, j_alt_dir, j_alt_en;
    assign j_alt_en = {j7_i2c | j7_can, j6_i2c | j6_can, 2'h0};
    assign j_alt_out = {j7_can & can_transmit_out, 1'h0, 2'h0};
    assign j_alt_dir = {j7_can | (j7_i2c & i2c_scl_drive_low),
        j6_i2c & i2c_sda_drive_low, 2'h0};
    phm_pad_if #(.W(PHM_J_W)) j_if ();
    assign j_if.gp_out = port_j_out;
    assign j_if.gp_dir = port_j_dir;
    assign j_if.alt_out = j_alt_out;
    assign j_if.alt_dir = j_alt_dir;
    assign j_if.alt_en = j_alt_en;
    phm_pad_mux #(.W(PHM_J_W)) u_j_mux (.clk(clk), .srst(srst), .pads(j_if.mux));
    assign port_j_pin_out = j_if.pin_out;
    assign port_j_pin_oe_n = j_if.pin_oe_n;

    ////////////////////////////////////////////////////////////////////////////
    // Port K: expanded modes take the whole port for the external bus
    logic [PHM_K_W-1:0] k_alt_out;
    assign k_alt_out = {~emulation_cs_active, expanded_bus_upper_address};
    phm_pad_if #(.W(PHM_K_W)) k_if ();
    assign k_if.gp_out = port_k_out;
    assign k_if.gp_dir = port_k_dir;
    assign k_if.alt_out = k_alt_out;
    assign k_if.alt_dir = '1;
    assign k_if.alt_en = {PHM_K_W{expanded_mode}};
    phm_pad_mux #(.W(PHM_K_W)) u_k_mux (.clk(clk), .srst(srst), .pads(k_if.mux));
    assign port_k_pin_out = k_if.pin_out;
    assign port_k_pin_oe_n = k_if.pin_oe_n;

    ////////////////////////////////////////////////////////////////////////////
    // Port M: pins 7 and 6 never leave general I/O
    logic [PHM_M_W-1:0] m_alt_out, m_alt_dir, m_alt_en;
    assign m_alt_en = {2'h0, m5_can | m5_spi, m4_can | m4_spi};
    assign m_alt_out = {2'h0, (m5_can & can_transmit_out) | (m5_spi & spi_sck_out),
        m4_spi & spi_mosi_out};
    assign m_alt_dir = {2'h0, m5_can | (m5_spi & spi_sck_oe), m4_spi & spi_master};
    phm_pad_if #(.W(PHM_M_W)) m_if ();
    assign m_if.gp_out = port_m_out;
    assign m_if.gp_dir = port_m_dir;
    assign m_if.alt_out = m_alt_out;
    assign m_if.alt_dir = m_alt_dir;
    assign m_if.alt_en = m_alt_en;
    phm_pad_mux #(.W(PHM_M_W)) u_m_mux (.clk(clk), .srst(srst), .pads(m_if.mux));
    assign port_m_pin_out = m_if.pin_out;
    assign port_m_pin_oe_n = m_if.pin_oe_n;

    ////////////////////////////////////////////////////////////////////////////
    // Wake-up detectors; edges only, so a held level does not retrigger
    phm_wake_det #(.W(PHM_H_W)) u_h_wake (
        .clk(clk),
        .srst(srst),
        .pin_in(port_h_pin_in),
        .wake_en(port_h_wake_en),
        .wake_rise(port_h_wake_rise),
        .flag_clr(port_h_wake_clr),
        .flag(port_h_wake_input)
    );
    phm_wake_det #(.W(PHM_J_W)) u_j_wake (
        .clk(clk),
        .srst(srst),
        .pin_in(port_j_pin_in),
        .wake_en(port_j_wake_en),
        .wake_rise(port_j_wake_rise),
        .flag_clr(port_j_wake_clr),
        .flag(port_j_wake_input)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Peripheral inputs; unselected I2C and CAN inputs idle high, unselected SPI inputs idle low
    logic scl_next, sda_next, canrx_next, sck_next, mosi_next, wake_next;
    assign scl_next = j7_i2c ? port_j_pin_in[PHM_J_P7] : 1'h1;
    assign sda_next = j6_i2c ? port_j_pin_in[PHM_J_P6] : 1'h1;
    assign canrx_next = j6_can ? port_j_pin_in[PHM_J_P6] :
        m4_can ? port_m_pin_in[PHM_M_P4] : 1'h1;
    assign sck_next = m5_spi ? port_m_pin_in[PHM_M_P5] : 1'h0;
    assign mosi_next = (m4_spi & ~spi_master) ? port_m_pin_in[PHM_M_P4] : 1'h0;
    assign wake_next = (|port_h_wake_input) | (|port_j_wake_input);

    logic scl_reg, sda_reg, canrx_reg, sck_reg, mosi_reg, wake_reg;
    always_ff @(posedge clk) begin
        if (srst) begin
            scl_reg <= 1'h1;
            sda_reg <= 1'h1;
            canrx_reg <= 1'h1;
            sck_reg <= 1'h0;
            mosi_reg <= 1'h0;
            wake_reg <= 1'h0;
        end else begin
            scl_reg <= scl_next;
            sda_reg <= sda_next;
            canrx_reg <= canrx_next;
            sck_reg <= sck_next;
            mosi_reg <= mosi_next;
            wake_reg <= wake_next;
        end
    end
    assign i2c_scl_in = scl_reg;
    assign i2c_sda_in = sda_reg;
    assign can_receive_in = canrx_reg;
    assign spi_sck_in = sck_reg;
    assign spi_mosi_in = mosi_reg;
    assign wake_request = wake_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Strap capture: first clocked edge after reset falls; pad still input then
    logic srst_d_reg, flash_map_reg;
    wire flash_map_strap = port_k_pin_in[PHM_K_CS];
    always_ff @(posedge clk) begin
        srst_d_reg <= srst;
        if (srst) begin
            flash_map_reg <= PHM_FLASH_MAP_RST;
        end else if (srst_d_reg) begin
            flash_map_reg <= flash_map_strap;
        end
    end
    assign flash_map_enable_bit = flash_map_reg;
endmodule // phm_port_mux
`default_nettype wire

/* verification/phm_pad_model.sv */
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Board side of one pad group: a driven pad shows the mux drive, a released
// pad shows what the board puts on it, never the last driven value
module phm_pad_model #(
    parameter int W = 4
) (
    input wire logic [W-1:0] drv, // Mux drive level
    input wire logic [W-1:0] oe_n, // Mux enable, low drives
    input wire logic [W-1:0] ext, // Board level when released
    output logic [W-1:0] lvl // Level seen at the pad
);
    timeunit 1ns;
    timeprecision 1ps;
    // Per-bit resolution; the board yields wherever the mux drives
    assign lvl = (drv & ~oe_n) | (ext & oe_n);
endmodule // phm_pad_model
`default_nettype wire

/* verification/phm_monitor.sv */
`default_nettype none
module phm_monitor
    import phm_pkg::*;
(
    input wire logic clk, // Bus clock
    input wire logic srst, // Sync reset
    input wire logic expanded_mode, // Bus mode
    input wire logic [PHM_H_W-1:0] port_h_dir, // H direction
    input wire logic [PHM_K_W-1:0] port_k_dir, // K direction
    input wire logic [PHM_M_W-1:0] port_m_dir, // M direction
    input wire logic [PHM_H_W-1:0] port_h_wake_en, // H wake enable
    input wire logic [PHM_H_W-1:0] port_h_wake_rise, // H polarity
    input wire logic [1:0] pj7_fn_sel, // J7 select
    input wire logic [1:0] pm5_fn_sel, // M5 select
    input wire logic [1:0] pm4_fn_sel, // M4 select
    input wire logic can_transmit_out, // CAN transmit
    input wire logic spi_sck_oe, // SPI clock drive
    input wire logic spi_master, // SPI master
    input wire logic emulation_cs_active, // Emulation select
    input wire logic [PHM_EXPANDED_BUS_UPPER_ADDRESS_W-1:0] expanded_bus_upper_address, // Upper address
    input wire logic [PHM_H_W-1:0] port_h_pin_in, // H pads
    input wire logic [PHM_K_W-1:0] port_k_pin_in, // K pads
    input wire logic [PHM_H_W-1:0] port_h_pin_oe_n, // H enable
    input wire logic [PHM_J_W-1:0] port_j_pin_out, // J drive
    input wire logic [PHM_J_W-1:0] port_j_pin_oe_n, // J enable
    input wire logic [PHM_K_W-1:0] port_k_pin_out, // K drive
    input wire logic [PHM_K_W-1:0] port_k_pin_oe_n, // K enable
    input wire logic [PHM_M_W-1:0] port_m_pin_oe_n, // M enable
    input wire logic [PHM_H_W-1:0] port_h_wake_input, // H flags
    input wire logic [PHM_J_W-1:0] port_j_wake_input, // J flags
    input wire logic wake_request, // Wake out
    input wire logic flash_map_enable_bit // Strap bit
);
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////////////////////////////////////////
    // One domain; every check stands down while reset is held
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // Pad outputs are registered, so each cause is read one edge back
    h_gpio_dir_a: assert property (1 |=> port_h_pin_oe_n == ~$past(port_h_dir))
        else $error("port H enable does not follow direction");
    k_gpio_dir_a: assert property (!expanded_mode |=> port_k_pin_oe_n == ~$past(port_k_dir))
        else $error("port K enable does not follow direction");
    k_exp_bus_a: assert property (expanded_mode |=> port_k_pin_oe_n == '0 &&
        port_k_pin_out == {~$past(emulation_cs_active), $past(expanded_bus_upper_address)})
        else $error("port K does not carry select and address");
    m_gpio_only_a: assert property (1 |=> port_m_pin_oe_n[3:2] == ~$past(port_m_dir[3:2]))
        else $error("port M upper pins not plain I/O");
    j7_can_tx_a: assert property (pj7_fn_sel == PHM_FN_ALT_B |=>
        !port_j_pin_oe_n[PHM_J_P7] && port_j_pin_out[PHM_J_P7] == $past(can_transmit_out))
        else $error("pin J7 does not carry CAN transmit");
    m5_spi_clk_a: assert property (pm5_fn_sel == PHM_FN_ALT_B |->
        ##1 port_m_pin_oe_n[PHM_M_P5] == !$past(spi_sck_oe))
        else $error("pin M5 drive not set by SPI clock enable");
    m4_spi_dir_a: assert property (pm4_fn_sel == PHM_FN_ALT_B |=>
        port_m_pin_oe_n[PHM_M_P4] == !$past(spi_master))
        else $error("pin M4 drive not set by SPI mode");
    wake_or_a: assert property ((port_h_wake_input != '0 || port_j_wake_input != '0) |=>
        wake_request) else $error("wake request missing with a flag set");
    h_wake_rise_a: assert property ($rose(port_h_pin_in[3]) && port_h_wake_en[3] &&
        port_h_wake_rise[3] && !$past(srst) |=> port_h_wake_input[3])
        else $error("rising edge did not set wake flag");
    strap_take_a: assert property ($fell(srst) |=>
        flash_map_enable_bit == $past(port_k_pin_in[PHM_K_CS]))
        else $error("strap not captured at reset release");
    strap_hold_a: assert property (!$fell(srst) |=> $stable(flash_map_enable_bit))
        else $error("strap bit changed after capture");
    // Main scenarios reached
    cover property (expanded_mode ##1 expanded_mode);
    cover property ($rose(wake_request));
    cover property (pj7_fn_sel == PHM_FN_ALT_B ##1 pm4_fn_sel == PHM_FN_ALT_B);
endmodule // phm_monitor
bind phm_port_mux phm_monitor u_mon (.clk, .srst, .expanded_mode, .port_h_dir, .port_k_dir,
    .port_m_dir, .port_h_wake_en, .port_h_wake_rise, .pj7_fn_sel, .pm5_fn_sel, .pm4_fn_sel,
    .can_transmit_out, .spi_sck_oe, .spi_master, .emulation_cs_active,
    .expanded_bus_upper_address, .port_h_pin_in, .port_k_pin_in, .port_h_pin_oe_n,
    .port_j_pin_out, .port_j_pin_oe_n, .port_k_pin_out, .port_k_pin_oe_n, .port_m_pin_oe_n,
    .port_h_wake_input, .port_j_wake_input, .wake_request, .flash_map_enable_bit);
`default_nettype wire

/* verification/tb.sv */
`default_nettype none
module tb
    import phm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, srst, expanded_mode, wake_request, flash_map_enable_bit;
    logic [6:0] port_h_out, port_h_dir, port_h_wake_en, port_h_wake_rise, port_h_wake_clr;
    logic [6:0] port_h_pin_in, port_h_pin_out, port_h_pin_oe_n, port_h_wake_input, ext_h;
    logic [3:0] port_j_out, port_j_dir, port_j_wake_en, port_j_wake_rise, port_j_wake_clr;
    logic [3:0] port_j_pin_in, port_j_pin_out, port_j_pin_oe_n, port_j_wake_input, ext_j;
    logic [6:0] port_k_out, port_k_dir, port_k_pin_in, port_k_pin_out, port_k_pin_oe_n, ext_k;
    logic [3:0] port_m_out, port_m_dir, port_m_pin_in, port_m_pin_out, port_m_pin_oe_n, ext_m;
    logic [1:0] pj7_fn_sel, pj6_fn_sel, pm5_fn_sel, pm4_fn_sel;
    logic i2c_scl_drive_low, i2c_sda_drive_low, can_transmit_out, spi_sck_out, spi_sck_oe;
    logic spi_mosi_out, spi_master, emulation_cs_active;
    logic [5:0] expanded_bus_upper_address;
    logic i2c_scl_in, i2c_sda_in, can_receive_in, spi_sck_in, spi_mosi_in;
    int fails, check_count;
    ////////////////////////////////////////////////////////////////////////////
    phm_port_mux DUT (.clk, .srst, .expanded_mode, .port_h_out, .port_h_dir, .port_j_out,
        .port_j_dir, .port_k_out, .port_k_dir, .port_m_out, .port_m_dir, .port_h_wake_en,
        .port_h_wake_rise, .port_h_wake_clr, .port_j_wake_en, .port_j_wake_rise,
        .port_j_wake_clr, .pj7_fn_sel, .pj6_fn_sel, .pm5_fn_sel, .pm4_fn_sel,
        .i2c_scl_drive_low, .i2c_sda_drive_low, .can_transmit_out, .spi_sck_out, .spi_sck_oe,
        .spi_mosi_out, .spi_master, .emulation_cs_active, .expanded_bus_upper_address,
        .port_h_pin_in, .port_j_pin_in, .port_k_pin_in, .port_m_pin_in, .port_h_pin_out,
        .port_h_pin_oe_n, .port_j_pin_out, .port_j_pin_oe_n, .port_k_pin_out,
        .port_k_pin_oe_n, .port_m_pin_out, .port_m_pin_oe_n, .i2c_scl_in, .i2c_sda_in,
        .can_receive_in, .spi_sck_in, .spi_mosi_in, .port_h_wake_input, .port_j_wake_input,
        .wake_request, .flash_map_enable_bit);
    // Board side of each pad group
    phm_pad_model #(.W(7)) u_ph (.drv(port_h_pin_out), .oe_n(port_h_pin_oe_n),
        .ext(ext_h), .lvl(port_h_pin_in));
    phm_pad_model #(.W(4)) u_pj (.drv(port_j_pin_out), .oe_n(port_j_pin_oe_n),
        .ext(ext_j), .lvl(port_j_pin_in));
    phm_pad_model #(.W(7)) u_pk (.drv(port_k_pin_out), .oe_n(port_k_pin_oe_n),
        .ext(ext_k), .lvl(port_k_pin_in));
    phm_pad_model #(.W(4)) u_pm (.drv(port_m_pin_out), .oe_n(port_m_pin_oe_n),
        .ext(ext_m), .lvl(port_m_pin_in));
    ////////////////////////////////////////////////////////////////////////////
    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Inputs move 1 ns after the edge so no race with the design's sampling
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        if (fails == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Strap is taken once at release and then held whatever the pad does
    task automatic do_reset(input logic strap);
        ext_k[6] = strap;
        srst = 1'b1;
        step(10);
        chk(port_h_pin_oe_n, 7'h7f);
        srst = 1'b0;
        step(2);
        chk(flash_map_enable_bit, strap);
        ext_k[6] = ~strap;
        step(2);
        chk(flash_map_enable_bit, strap);
        chk({port_h_wake_input, port_j_wake_input}, 11'h000);
    endtask
    task automatic t_gpio;
        {ext_h, ext_j, ext_k, ext_m} = '0;
        port_h_dir = 7'h55;
        port_h_out = 7'h7f;
        port_j_dir = 4'h3;
        port_j_out = 4'h1;
        port_k_dir = 7'h0f;
        port_k_out = 7'h05;
        port_m_dir = 4'hf;
        port_m_out = 4'ha;
        step(2);
        chk({port_h_pin_oe_n, port_h_pin_in}, {7'h2a, 7'h55});
        chk({port_j_pin_oe_n, port_j_pin_in}, {4'hc, 4'h1});
        chk({port_k_pin_oe_n, port_k_pin_in}, {7'h70, 7'h05});
        chk({port_m_pin_oe_n, port_m_pin_in}, {4'h0, 4'ha});
    endtask
    // Expanded mode takes port K even with every direction bit at input
    task automatic t_kexp;
        port_k_dir = '0;
        expanded_mode = 1'b1;
        emulation_cs_active = 1'b1;
        expanded_bus_upper_address = 6'h2d;
        step(2);
        chk({port_k_pin_oe_n, port_k_pin_out}, {7'h00, 7'h2d});
        emulation_cs_active = 1'b0;
        expanded_bus_upper_address = 6'h12;
        step(2);
        chk(port_k_pin_out, 7'h52);
        expanded_mode = 1'b0;
        step(2);
        chk(port_k_pin_oe_n, 7'h7f);
    endtask
    // Every select code on J7, J6, M5 and M4 at once; GP direction left input
    task automatic t_alt;
        logic [3:0] oe_tab [4];
        logic [2:0] lvl_tab [4];
        logic [2:0] in_tab [4];
        oe_tab = '{4'hf, 4'h1, 4'h4, 4'hf};
        lvl_tab = '{3'b100, 3'b010, 3'b101, 3'b100};
        in_tab = '{3'b111, 3'b000, 3'b110, 3'b111};
        {port_j_dir, port_m_dir, ext_m, spi_sck_out} = '0;
        ext_j = 4'h8;
        {i2c_scl_drive_low, i2c_sda_drive_low, can_transmit_out} = 3'h7;
        {spi_sck_oe, spi_mosi_out, spi_master} = 3'h7;
        for (int s = 0; s < 4; s++) begin
            {pj7_fn_sel, pj6_fn_sel, pm5_fn_sel, pm4_fn_sel} = {4{s[1:0]}};
            step(2);
            chk({port_j_pin_oe_n[3:2], port_m_pin_oe_n[1:0]}, oe_tab[s]);
            chk({port_j_pin_in[3], port_m_pin_in[1:0]}, lvl_tab[s]);
            chk({i2c_scl_in, i2c_sda_in, can_receive_in}, in_tab[s]);
        end
        {spi_sck_oe, spi_master} = 2'h0;
        ext_m = 4'h3;
        {pm5_fn_sel, pm4_fn_sel} = {2{PHM_FN_ALT_B}};
        step(2);
        chk({port_m_pin_oe_n[1:0], spi_sck_in, spi_mosi_in}, 4'hf);
        {pj7_fn_sel, pj6_fn_sel, pm5_fn_sel, pm4_fn_sel} = '0;
    endtask
    // Pin 3 rises as armed, pin 4 rises against its polarity, pin 5 is not armed
    task automatic t_wake;
        int i;
        {port_h_dir, port_j_dir, ext_h} = '0;
        ext_j = 4'h1;
        step(2);
        port_h_wake_en = 7'h38;
        port_h_wake_rise = 7'h0f;
        port_h_wake_en[5] = 1'b0;
        port_j_wake_en = 4'h1;
        port_j_wake_rise = 4'h0;
        step(1);
        ext_h = 7'h38;
        ext_j = 4'h0;
        for (i = 0; i < 8 && wake_request !== 1'b1; i++) step(1);
        if (wake_request !== 1'b1) begin
            fails++;
            give_verdict();
        end
        chk({port_h_wake_input, port_j_wake_input}, {7'h08, 4'h1});
        port_h_wake_clr = 7'h7f;
        port_j_wake_clr = 4'hf;
        step(1);
        {port_h_wake_clr, port_j_wake_clr} = '0;
        step(2);
        chk({wake_request, port_h_wake_input, port_j_wake_input}, 12'h000);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence; ends with a second reset using the other strap level
    initial begin
        {fails, check_count} = '0;
        {srst, expanded_mode, port_h_out, port_h_dir, port_h_wake_en, port_h_wake_rise} = '1;
        {port_h_wake_clr, port_j_out, port_j_dir, port_j_wake_en, port_j_wake_rise} = '0;
        {port_j_wake_clr, port_k_out, port_k_dir, port_m_out, port_m_dir} = '0;
        {pj7_fn_sel, pj6_fn_sel, pm5_fn_sel, pm4_fn_sel, expanded_bus_upper_address} = '0;
        {i2c_scl_drive_low, i2c_sda_drive_low, can_transmit_out, spi_sck_out} = '0;
        {spi_sck_oe, spi_mosi_out, spi_master, emulation_cs_active} = '0;
        {expanded_mode, port_h_out, port_h_dir, port_h_wake_en, port_h_wake_rise} = '0;
        {ext_h, ext_j, ext_k, ext_m} = '1;
        do_reset(1'b1);
        t_gpio();
        t_kexp();
        t_alt();
        t_wake();
        do_reset(1'b0);
        give_verdict();
    end
endmodule // tb
`default_nettype wire
